// ### hw/flag_cell.sv
// one group of condition flags with read-clear and self-clear behaviour
`timescale 1ns/1ps
module flag_cell #(
   parameter logic [7:0] IMPL = 8'hFF
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // conditions and clearing
   input wire logic [7:0] cond_in,
   input wire logic self_clear_in,
   input wire logic read_clear_in,
   // flag state
   output logic [7:0] flags_out
);
   import irq_mask_pkg::*;

   logic [7:0] flags_q;
   logic [7:0] flags_d;

   // next flag values; a condition present in the read cycle keeps its flag
   always_comb begin
      if (self_clear_in) begin
         // RULE6 flags follow condition
         flags_d = cond_in & IMPL;
      end else if (read_clear_in) begin
         // RULE7 read clears all flags except those whose condition is still present
         flags_d = cond_in & IMPL;
      end else begin
         flags_d = (flags_q | cond_in) & IMPL;
      end
   end

   // flag register
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         flags_q <= FLAG_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags_out = flags_q;

endmodule

// ### hw/irq_mask_pkg.sv
// constants, field layouts and carrier types of the charger interrupt enable logic
//
// Behaviour
// RULE1 - enable reg 0x7 gates group-0 flags
// RULE2 - enable bit 0 blocks, 1 passes flag
// RULE3 - enable reg 0x8 gates group-1 faults
// RULE4 - enable reg 0x9 gates group-2, reserved bits
// RULE5 - all enable bits reset zero, read-write
// RULE6 - bit 7 selects self-clearing flags
// RULE7 - group-0 flags read-only, cleared by read
package irq_mask_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int GROUPS = 3;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_EN_GRP0 = 8'h07;
   localparam logic [ADDR_W-1:0] OFS_EN_GRP1 = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_EN_GRP2 = 8'h09;
   localparam logic [ADDR_W-1:0] OFS_FLAG_GRP0 = 8'h0A;
   localparam logic [ADDR_W-1:0] OFS_FLAG_GRP1 = 8'h0B;
   localparam logic [ADDR_W-1:0] OFS_FLAG_GRP2 = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0D;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0E;

   ////////////////////////////////////////////////////////////////////////////
   // field positions, group 0
   localparam int BIT_SELF_CLEAR = 7;
   localparam int BIT_UNCONFIGURED = 7;
   localparam int BIT_TYPEC_STATE_CHANGE = 5;
   localparam int BIT_TYPEC_ATTACH_STATUS = 4;
   localparam int BIT_CHARGER_ATTACH_STATUS = 3;
   localparam int BIT_TYPEC_ATTACH_EVENT = 2;
   localparam int BIT_CHARGER_ATTACH_EVENT = 1;
   localparam int BIT_CONVERSION_DONE = 0;
   // field positions, group 1
   localparam int BIT_BUS_PRE_OVERVOLTAGE = 6;
   localparam int BIT_BUS_LIMIT_UNDERVOLTAGE = 5;
   localparam int BIT_BUS_CURRENT_LIMIT = 4;
   localparam int BIT_BUS_OVERVOLTAGE = 3;
   localparam int BIT_BUS_UNDERVOLTAGE = 2;
   localparam int BIT_BUS_SHORT_GROUND = 1;
   localparam int BIT_THERMAL_SHUTDOWN = 0;
   // field positions, group 2
   localparam int BIT_BUS_PREBIAS = 5;
   localparam int BIT_THERMAL_WARNING = 3;
   localparam int BIT_INPUT_OVERVOLTAGE = 2;
   localparam int BIT_DATALINE_OVERVOLTAGE = 1;

   ////////////////////////////////////////////////////////////////////////////
   // implemented bits and reset values
   localparam logic [DATA_W-1:0] FLAG_IMPL [GROUPS] = '{8'h3F, 8'h7F, 8'h2E};
   localparam logic [DATA_W-1:0] EN0_WRITABLE = 8'hBF;
   localparam logic [DATA_W-1:0] EN_RESET = 8'h00;
   localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
   localparam logic [GROUPS-1:0] STATUS_RESET = 3'h0;
   localparam logic [GROUPS-1:0] SUMMARY_MASK_RESET = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic typec_state_change;
      logic typec_attach_status;
      logic charger_attach_status;
      logic typec_attach_event;
      logic charger_attach_event;
      logic conversion_done;
   } grp0_cond_t;

   typedef struct packed {
      logic bus_pre_overvoltage;
      logic bus_limit_undervoltage;
      logic bus_current_limit;
      logic bus_overvoltage;
      logic bus_undervoltage;
      logic bus_short_ground;
      logic thermal_shutdown;
   } grp1_cond_t;

   typedef struct packed {
      logic bus_prebias;
      logic thermal_warning;
      logic input_overvoltage;
      logic dataline_overvoltage;
   } grp2_cond_t;

endpackage

// ### hw/usb_charger_irq_mask_logic.sv
// interrupt enable logic of the charging-port controller
`timescale 1ns/1ps
module usb_charger_irq_mask_logic (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // register port
   input wire irq_mask_pkg::reg_req_t reg_req_in,
   output logic [irq_mask_pkg::DATA_W-1:0] rdata_out,
   // condition inputs
   input wire irq_mask_pkg::grp0_cond_t grp0_cond_in,
   input wire irq_mask_pkg::grp1_cond_t grp1_cond_in,
   input wire irq_mask_pkg::grp2_cond_t grp2_cond_in,
   input wire logic unconfigured_in,
   // interrupt toward the host
   output logic irq_out
);
   import irq_mask_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   // enable registers, one byte per group;
   // group 0 also carries the self-clear selector
   logic [DATA_W-1:0] irq_enable_group0_q;
   logic [DATA_W-1:0] irq_enable_group0_d;
   logic [DATA_W-1:0] irq_enable_group1_q;
   logic [DATA_W-1:0] irq_enable_group1_d;
   logic [DATA_W-1:0] irq_enable_group2_q;
   logic [DATA_W-1:0] irq_enable_group2_d;

   // summary status and its mask
   // status bits are sticky, one per group
   logic [GROUPS-1:0] irq_status_q;
   logic [GROUPS-1:0] irq_status_d;
   logic [GROUPS-1:0] irq_summary_mask_q;
   logic [GROUPS-1:0] irq_summary_mask_d;

   // output flops; nothing combinational reaches a pin,
   // so the host never sees a glitch on the line
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic irq_q;
   logic irq_d;

   // per group vectors
   // indexed by group so that the flag cells share one loop
   logic [DATA_W-1:0] cond_vec [GROUPS];
   logic [DATA_W-1:0] flags_vec [GROUPS];
   logic [DATA_W-1:0] enable_vec [GROUPS];
   logic [GROUPS-1:0] read_clear_vec;
   logic [GROUPS-1:0] pending;

   // decoded strobes
   // decoded once here and used by the next-state logic
   logic wr_en0;
   logic wr_en1;
   logic wr_en2;
   logic wr_status;
   logic wr_smask;
   logic flag_self_clear_select;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   // writes only land on the read-write registers; flag offsets ignore writes
   // a full address compare keeps aliases of a register off the map
   always_comb begin
      // each strobe needs both the write and its own offset
      wr_en0 = reg_req_in.wr && (reg_req_in.addr == OFS_EN_GRP0);
      wr_en1 = reg_req_in.wr && (reg_req_in.addr == OFS_EN_GRP1);
      wr_en2 = reg_req_in.wr && (reg_req_in.addr == OFS_EN_GRP2);
      wr_status = reg_req_in.wr && (reg_req_in.addr == OFS_IRQ_STATUS);
      wr_smask = reg_req_in.wr && (reg_req_in.addr == OFS_IRQ_MASK);
   end

   // a read of a flag register clears that group after the data is taken
   // only a read strobe clears; a write to a flag offset is dropped
   always_comb begin
      // RULE7 clear on read
      read_clear_vec[0] = reg_req_in.rd && (reg_req_in.addr == OFS_FLAG_GRP0);
      read_clear_vec[1] = reg_req_in.rd && (reg_req_in.addr == OFS_FLAG_GRP1);
      read_clear_vec[2] = reg_req_in.rd && (reg_req_in.addr == OFS_FLAG_GRP2);
   end

   ////////////////////////////////////////////////////////////////////////////
   // condition mapping onto register bit positions
   // the carriers list fields from high bit to low; mapping them through
   // named positions keeps the register layout in one place

   // group 0: type-C state change, attach status, attach events, conversion done
   // attach status is a level; attach events are single pulses
   always_comb begin
      // cleared first so that reserved positions read as zero
      cond_vec[0] = '0;
      cond_vec[0][BIT_TYPEC_STATE_CHANGE] = grp0_cond_in.typec_state_change;
      cond_vec[0][BIT_TYPEC_ATTACH_STATUS] = grp0_cond_in.typec_attach_status;
      cond_vec[0][BIT_CHARGER_ATTACH_STATUS] = grp0_cond_in.charger_attach_status;
      cond_vec[0][BIT_TYPEC_ATTACH_EVENT] = grp0_cond_in.typec_attach_event;
      cond_vec[0][BIT_CHARGER_ATTACH_EVENT] = grp0_cond_in.charger_attach_event;
      cond_vec[0][BIT_CONVERSION_DONE] = grp0_cond_in.conversion_done;
   end

   // group 1: bus voltage and current faults, thermal shutdown
   // a fault may be a level that outlasts a read, and then stays flagged
   always_comb begin
      // bit 7 has no fault behind it
      cond_vec[1] = '0;
      cond_vec[1][BIT_BUS_PRE_OVERVOLTAGE] = grp1_cond_in.bus_pre_overvoltage;
      cond_vec[1][BIT_BUS_LIMIT_UNDERVOLTAGE] = grp1_cond_in.bus_limit_undervoltage;
      cond_vec[1][BIT_BUS_CURRENT_LIMIT] = grp1_cond_in.bus_current_limit;
      cond_vec[1][BIT_BUS_OVERVOLTAGE] = grp1_cond_in.bus_overvoltage;
      cond_vec[1][BIT_BUS_UNDERVOLTAGE] = grp1_cond_in.bus_undervoltage;
      cond_vec[1][BIT_BUS_SHORT_GROUND] = grp1_cond_in.bus_short_ground;
      cond_vec[1][BIT_THERMAL_SHUTDOWN] = grp1_cond_in.thermal_shutdown;
   end

   // group 2: prebias, thermal warning, overvoltage on input and data lines
   // data-line overvoltage is kept apart from input overvoltage
   always_comb begin
      // positions 7, 6, 4 and 0 are reserved
      cond_vec[2] = '0;
      cond_vec[2][BIT_BUS_PREBIAS] = grp2_cond_in.bus_prebias;
      cond_vec[2][BIT_THERMAL_WARNING] = grp2_cond_in.thermal_warning;
      cond_vec[2][BIT_INPUT_OVERVOLTAGE] = grp2_cond_in.input_overvoltage;
      cond_vec[2][BIT_DATALINE_OVERVOLTAGE] = grp2_cond_in.dataline_overvoltage;
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable registers

   // plain read-write storage; group 0 bit 6 is not stored
   // reserved positions are masked on the way in, so a readback
   // shows exactly what can take effect
   always_comb begin
      // hold unless written
      irq_enable_group0_d = irq_enable_group0_q;
      irq_enable_group1_d = irq_enable_group1_q;
      irq_enable_group2_d = irq_enable_group2_q;
      // one write lands on one register only
      if (wr_en0) begin
         // RULE1 group-0 enables
         irq_enable_group0_d = reg_req_in.wdata & EN0_WRITABLE;
      end
      if (wr_en1) begin
         // RULE3 group-1 enables
         irq_enable_group1_d = reg_req_in.wdata & FLAG_IMPL[1];
      end
      if (wr_en2) begin
         // RULE4 reserved bits dropped
         irq_enable_group2_d = reg_req_in.wdata & FLAG_IMPL[2];
      end
   end

   // no flag reaches the line until software sets an enable
   // RULE5 enables reset zero
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         irq_enable_group0_q <= EN_RESET;
         irq_enable_group1_q <= EN_RESET;
         irq_enable_group2_q <= EN_RESET;
      end else begin
         irq_enable_group0_q <= irq_enable_group0_d;
         irq_enable_group1_q <= irq_enable_group1_d;
         irq_enable_group2_q <= irq_enable_group2_d;
      end
   end

   // the self-clear selector shares the group-0 enable register
   // bit 7 is masked off the group-0 enables so that the selector
   // never counts as a pending flag
   always_comb begin
      flag_self_clear_select = irq_enable_group0_q[BIT_SELF_CLEAR];
      enable_vec[0] = irq_enable_group0_q & FLAG_IMPL[0];
      enable_vec[1] = irq_enable_group1_q;
      enable_vec[2] = irq_enable_group2_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag groups

   // one flag cell per group; reserved positions are held at zero inside
   // the selector is shared: self-clear acts on all groups at once
   for (genvar g = 0; g < GROUPS; g++) begin : g_flags
      // the implemented-bit mask comes from the package table
      flag_cell #(
         .IMPL(FLAG_IMPL[g])
      ) u_flag_cell (
         .clk_in(clk_in),
         .reset_n_in(reset_n_in),
         .cond_in(cond_vec[g]),
         .self_clear_in(flag_self_clear_select),
         .read_clear_in(read_clear_vec[g]),
         .flags_out(flags_vec[g])
      );

      // a flag only counts while its enable bit is set
      // RULE2 enable gates flag
      assign pending[g] = |(flags_vec[g] & enable_vec[g]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // summary status, summary mask and interrupt line

   // sticky per group; a new pending wins over a write-one clear in the same
   // cycle so that no event slips through while software acknowledges
   // the summary mask resets to all ones, so by default the
   // enable registers alone decide the line
   always_comb begin
      irq_status_d = irq_status_q;
      irq_summary_mask_d = irq_summary_mask_q;
      // write one to clear, per group bit
      if (wr_status) begin
         irq_status_d = irq_status_q & ~reg_req_in.wdata[GROUPS-1:0];
      end
      // set after the clear, so a new pending is never lost
      irq_status_d = irq_status_d | pending;
      // a mask change reaches the line at the same edge
      if (wr_smask) begin
         irq_summary_mask_d = reg_req_in.wdata[GROUPS-1:0];
      end
      // computed from next state so the line tracks status with no extra lag
      irq_d = |(irq_status_d & irq_summary_mask_d);
   end

   // limitation: the line follows status, so software clears the
   // status bit only after the flag, or the line rises again
   // status, mask and interrupt flops
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         // reset leaves the summary mask open and the status clear
         irq_status_q <= STATUS_RESET;
         irq_summary_mask_q <= SUMMARY_MASK_RESET;
         irq_q <= 1'b0;
      end else begin
         irq_status_q <= irq_status_d;
         irq_summary_mask_q <= irq_summary_mask_d;
         irq_q <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data

   // data stand only in the cycle after the read strobe, zero otherwise;
   // flag reads see the value before the clear that the same read causes
   // a zero outside the answer cycle lets a host or-combine several
   // answer buses with no extra gating
   always_comb begin
      rdata_d = READ_UNMAPPED;
      // nothing is returned without a read strobe
      if (reg_req_in.rd) begin
         // every mapped offset is listed; the default covers the holes
         unique case (reg_req_in.addr)
            OFS_EN_GRP0: begin
               rdata_d = irq_enable_group0_q;
            end
            OFS_EN_GRP1: begin
               rdata_d = irq_enable_group1_q;
            end
            OFS_EN_GRP2: begin
               rdata_d = irq_enable_group2_q;
            end
            OFS_FLAG_GRP0: begin
               rdata_d = flags_vec[0];
               rdata_d[BIT_UNCONFIGURED] = unconfigured_in; // not cleared by read
            end
            OFS_FLAG_GRP1: begin
               rdata_d = flags_vec[1];
            end
            OFS_FLAG_GRP2: begin
               rdata_d = flags_vec[2];
            end
            OFS_IRQ_STATUS: begin
               rdata_d = {{(DATA_W-GROUPS){1'b0}}, irq_status_q};
            end
            OFS_IRQ_MASK: begin
               rdata_d = {{(DATA_W-GROUPS){1'b0}}, irq_summary_mask_q};
            end
            default: begin
               rdata_d = READ_UNMAPPED;
            end
         endcase
      end
   end

   // read data register
   // registered so that the answer stands one cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rdata_q <= READ_UNMAPPED;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   // both pins are taken from flops only, never from decode logic

   assign rdata_out = rdata_q;
   assign irq_out = irq_q;

endmodule

// ### verification/host_model.sv
// host-side register master for the charger interrupt logic
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic clk_in,
   // register port
   input wire logic [irq_mask_pkg::DATA_W-1:0] rdata_in,
   output irq_mask_pkg::reg_req_t req_out
);
   import irq_mask_pkg::*;
   initial req_out = '0;
   // strobe cycle then idle cycle, so strobes never overlap
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      req_out <= '0;
   endtask
   // data stand only in the cycle after the strobe, taken mid-cycle
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      req_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      req_out <= '0;
      @(negedge clk_in);
      d = rdata_in;
   endtask
endmodule

// ### verification/irq_mask_chk.sv
// assertion checker for the charger interrupt enable logic
`timescale 1ns/1ps
module irq_mask_chk (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // watched ports
   input wire irq_mask_pkg::reg_req_t reg_req_in,
   input wire logic [irq_mask_pkg::DATA_W-1:0] rdata_out,
   input wire irq_mask_pkg::grp0_cond_t grp0_cond_in,
   input wire irq_mask_pkg::grp1_cond_t grp1_cond_in,
   input wire irq_mask_pkg::grp2_cond_t grp2_cond_in,
   input wire logic unconfigured_in,
   input wire logic irq_out
);
   import irq_mask_pkg::*;
   logic wr;
   logic rd;
   logic [7:0] ad;
   logic cnd;
   logic wrote_q;
   logic wrote_d;
   logic [2:0] en_nz_q;
   logic [2:0] en_nz_d;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // short names for the request fields
   assign wr = reg_req_in.wr;
   assign rd = reg_req_in.rd;
   assign ad = reg_req_in.addr;
   assign cnd = |{grp0_cond_in, grp1_cond_in, grp2_cond_in};
   // an enable write must land before any interrupt is possible
   always_comb begin
      wrote_d = wrote_q | (wr & (ad inside {OFS_EN_GRP0, OFS_EN_GRP1, OFS_EN_GRP2}));
   end
   always_ff @(posedge clk_in) begin
      wrote_q <= reset_n_in ? wrote_d : 1'b0;
   end
   // shadow of which groups hold any implemented enable bit, rebuilt from the writes
   always_comb begin
      en_nz_d = en_nz_q;
      for (int g = 0; g < 3; g++) begin
         if (wr && ad == OFS_EN_GRP0 + 8'(g)) begin
            en_nz_d[g] = |(reg_req_in.wdata & FLAG_IMPL[g]);
         end
      end
   end
   always_ff @(posedge clk_in) begin
      en_nz_q <= reset_n_in ? en_nz_d : 3'h0;
   end
   chk_irq_gated: assert property (!wrote_q |-> !irq_out)
      else $error("interrupt before any enable write");
   chk_en0_rdback: assert property (wr && ad == OFS_EN_GRP0 ##1 !wr ##1 rd && ad == OFS_EN_GRP0
      |=> rdata_out == ($past(reg_req_in.wdata, 3) & 8'hBF))
      else $error("group 0 enable readback wrong");
   chk_en1_rdback: assert property (wr && ad == OFS_EN_GRP1 ##1 !wr ##1 rd && ad == OFS_EN_GRP1
      |=> rdata_out == ($past(reg_req_in.wdata, 3) & 8'h7F))
      else $error("group 1 enable readback wrong");
   chk_en2_rdback: assert property (wr && ad == OFS_EN_GRP2 ##1 !wr ##1 rd && ad == OFS_EN_GRP2
      |=> rdata_out == ($past(reg_req_in.wdata, 3) & 8'h2E))
      else $error("group 2 enable readback wrong");
   chk_reset_quiet: assert property ($rose(reset_n_in) |-> !irq_out && rdata_out == 8'h00)
      else $error("outputs not quiet after reset");
   chk_flag_rdclr: assert property (rd && ad == OFS_FLAG_GRP0 && grp0_cond_in == '0 ##1 grp0_cond_in == '0
      ##1 rd && ad == OFS_FLAG_GRP0 |=> rdata_out == {$past(unconfigured_in), 7'h00})
      else $error("group 0 flags not cleared by read");
   chk_rdata_idle: assert property (!$past(rd) |-> rdata_out == 8'h00)
      else $error("read data outside the answer cycle");
   chk_irq_cause: assert property ($rose(irq_out) |-> $past(wr, 2) || $past(wr) || $past(cnd, 2) || $past(cnd))
      else $error("interrupt rose without a cause");
   chk_irq_needs_en: assert property ($rose(irq_out) |-> $past(|en_nz_q) || $past(wr))
      else $error("interrupt rose with every enable clear");
endmodule
bind usb_charger_irq_mask_logic irq_mask_chk chk_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .reg_req_in(reg_req_in), .rdata_out(rdata_out), .grp0_cond_in(grp0_cond_in), .grp1_cond_in(grp1_cond_in),
   .grp2_cond_in(grp2_cond_in), .unconfigured_in(unconfigured_in), .irq_out(irq_out));

// ### verification/testbench.sv
// self-checking bench for the charger interrupt enable logic
`timescale 1ns/1ps
module testbench;
   import irq_mask_pkg::*;
   logic clk_in;
   logic reset_n_in;
   reg_req_t req;
   logic [7:0] rdata;
   grp0_cond_t c0;
   grp1_cond_t c1;
   grp2_cond_t c2;
   logic unconf;
   logic irq;
   logic [7:0] impl [3] = '{8'h3F, 8'h7F, 8'h2E};
   logic [7:0] all1 [3] = '{8'hBF, 8'h7F, 8'h2E};
   int num_errors = 0;
   int comparisons = 0;
   usb_charger_irq_mask_logic dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_req_in(req), .rdata_out(rdata),
      .grp0_cond_in(c0), .grp1_cond_in(c1), .grp2_cond_in(c2), .unconfigured_in(unconf), .irq_out(irq));
   host_model host (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
   // 125 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   // one compare; an unknown never matches
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.rd_reg(a, v);
      check(what, exp, v);
   endtask
   task automatic irq_chk(input logic exp);
      @(negedge clk_in);
      check("irq", {7'h00, exp}, {7'h00, irq});
   endtask
   // hold one condition for n cycles; group 2 sits on sparse bits
   task automatic pulse(input int g, input int p, input int n);
      @(posedge clk_in);
      c0 <= (g == 0) ? 6'(1 << p) : 6'h00;
      c1 <= (g == 1) ? 7'(1 << p) : 7'h00;
      c2 <= (g == 2) ? {p == 5, p == 3, p == 2, p == 1} : 4'h0;
      repeat (n) @(posedge clk_in);
      c0 <= '0;
      c1 <= '0;
      c2 <= '0;
   endtask
   task automatic complete_run;
      $display("num_errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      num_errors++;
      complete_run();
   end
   initial begin
      reset_n_in = 1'b0;
      c0 = '0;
      c1 = '0;
      c2 = '0;
      unconf = 1'b1;
      repeat (10) @(posedge clk_in);
      reset_n_in <= 1'b1;
      irq_chk(1'b0);
      // reset values, writability and reserved bits
      for (int g = 0; g < 3; g++) begin
         rd_chk("enable reset", OFS_EN_GRP0 + 8'(g), EN_RESET);
         host.wr_reg(OFS_EN_GRP0 + 8'(g), 8'hFF);
         rd_chk("enable ones", OFS_EN_GRP0 + 8'(g), all1[g]);
         host.wr_reg(OFS_EN_GRP0 + 8'(g), 8'h00);
         rd_chk("enable zero", OFS_EN_GRP0 + 8'(g), 8'h00);
      end
      rd_chk("unmapped", 8'h30, READ_UNMAPPED);
      rd_chk("status reset", OFS_IRQ_STATUS, 8'h00);
      rd_chk("mask reset", OFS_IRQ_MASK, 8'h07);
      // every condition: blocked while disabled, passes once enabled, read clears
      for (int g = 0; g < 3; g++) begin
         for (int p = 0; p < 8; p++) begin
            if (impl[g][p]) begin
               pulse(g, p, 1);
               repeat (3) @(posedge clk_in);
               irq_chk(1'b0);
               host.wr_reg(OFS_EN_GRP0 + 8'(g), 8'(1 << p));
               repeat (3) @(posedge clk_in);
               irq_chk(1'b1);
               rd_chk("flag set", OFS_FLAG_GRP0 + 8'(g), 8'(1 << p) | (g == 0 ? 8'h80 : 8'h00));
               rd_chk("flag clear", OFS_FLAG_GRP0 + 8'(g), g == 0 ? 8'h80 : 8'h00);
               host.wr_reg(OFS_IRQ_STATUS, 8'h07);
               host.wr_reg(OFS_EN_GRP0 + 8'(g), 8'h00);
               irq_chk(1'b0);
            end
         end
      end
      // summary mask holds the line off; status stays set while its flag pends
      host.wr_reg(OFS_IRQ_MASK, 8'h06);
      host.wr_reg(OFS_EN_GRP0, 8'h01);
      pulse(0, BIT_CONVERSION_DONE, 1);
      repeat (3) @(posedge clk_in);
      irq_chk(1'b0);
      rd_chk("status", OFS_IRQ_STATUS, 8'h01);
      rd_chk("summary mask", OFS_IRQ_MASK, 8'h06);
      host.wr_reg(OFS_IRQ_MASK, 8'h07);
      irq_chk(1'b1);
      host.wr_reg(OFS_IRQ_STATUS, 8'h07);
      rd_chk("status kept", OFS_IRQ_STATUS, 8'h01);
      rd_chk("flag held", OFS_FLAG_GRP0, 8'h81);
      host.wr_reg(OFS_IRQ_STATUS, 8'h07);
      host.wr_reg(OFS_EN_GRP0, 8'h00);
      irq_chk(1'b0);
      // self-clearing flags follow the condition away
      host.wr_reg(OFS_EN_GRP0, 8'h81);
      pulse(0, BIT_CONVERSION_DONE, 4);
      irq_chk(1'b1);
      rd_chk("self clear", OFS_FLAG_GRP0, 8'h80);
      host.wr_reg(OFS_EN_GRP0, 8'h00);
      host.wr_reg(OFS_IRQ_STATUS, 8'h07);
      irq_chk(1'b0);
      @(posedge clk_in);
      unconf <= 1'b0;
      rd_chk("configured", OFS_FLAG_GRP0, 8'h00);
      complete_run();
   end
endmodule
